// ---- hw/processor_bus_arbiter.sv ----
// Address bus arbiter: bridge master plus three external masters.
// Assumes request and transfer start pins are synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Disabled external master's requests are ignored
// - Enable bits default from boot option
// - Each external master has priority bit
// - Bridge master has its own priority bit
// - Delayed sampling ignores lingering request after start
// - Idle bus parks on last or programmed master
// - Park field codes bridge, master1, master2, master3
// - One request/grant pin pair per external master
module processor_bus_arbiter
  import arb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic ce,
  input wire regbus_req_type regReq,
  output logic [DATA_W-1:0] regRdata,
  input wire logic bootFromHost,
  input wire logic transferStartN,
  input wire logic bridgeRequest,
  output logic bridgeGrant,
  input wire logic [3:1] busRequestN,
  output logic [3:1] busGrantN
);
  arb_state_type state_ff;
  arb_state_type nxt_state;
  logic [3:0] reqEn;
  logic [3:0] highReq;
  logic [3:0] winClass;
  logic sampleNow;
  logic hiAny;
  logic pickAny;
  logic [1:0] pickIdx;
  logic [DATA_W-1:0] ctrlWord;
  logic [DATA_W-1:0] statusWord;

  function automatic logic [3:0] onehot4(input logic [1:0] i);
    onehot4 = 4'h1 << i;
  endfunction

  // Bridge always eligible; externals gated by enable
  assign reqEn = {~busRequestN & state_ff.enable, bridgeRequest};
  assign highReq = reqEn & state_ff.prio;
  assign hiAny = |highReq;
  assign winClass = hiAny ? highReq : reqEn;
  // Cycle of the start strobe is never sampled; holdoff masks one more
  assign sampleNow = transferStartN && !state_ff.holdoff;

  rr_pick #(.N(MASTERS)) u_pick (
    .req(winClass),
    .last(state_ff.owner),
    .any(pickAny),
    .idx(pickIdx)
  );

  always_comb begin
    ctrlWord = ZERO_WORD;
    ctrlWord[EN_LSB +: 3] = state_ff.enable;
    ctrlWord[PRI_LSB +: 4] = state_ff.prio;
    ctrlWord[DLY_BIT] = state_ff.sampleDelay;
    ctrlWord[PARK_BIT] = state_ff.parkFixed;
    ctrlWord[SEL_LSB +: 2] = state_ff.parkSel;
    statusWord = ZERO_WORD;
    statusWord[ST_OWNER_LSB +: 2] = state_ff.owner;
    statusWord[ST_USED_BIT] = state_ff.used;
    statusWord[ST_HOLD_BIT] = state_ff.holdoff;
    statusWord[ST_GRANT_LSB +: 4] = state_ff.grant;
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.rdata = ZERO_WORD;
    if (state_ff.strapPending) begin
      // Strap caught after reset release, never under the reset itself
      nxt_state.enable = bootFromHost ? EN_BOOT_HOST : EN_BOOT_PROC;
      nxt_state.strapPending = 1'b0;
    end
    if (regReq.wr && regReq.addr == CTRL_OFFSET) begin
      nxt_state.enable = regReq.wdata[EN_LSB +: 3];
      nxt_state.prio = regReq.wdata[PRI_LSB +: 4];
      nxt_state.sampleDelay = regReq.wdata[DLY_BIT];
      nxt_state.parkFixed = regReq.wdata[PARK_BIT];
      nxt_state.parkSel = regReq.wdata[SEL_LSB +: 2];
    end
    if (regReq.rd) begin
      if (regReq.addr == CTRL_OFFSET) begin
        nxt_state.rdata = ctrlWord;
      end else if (regReq.addr == STATUS_OFFSET) begin
        nxt_state.rdata = statusWord;
      end
    end
    if (!transferStartN) begin
      nxt_state.holdoff = state_ff.sampleDelay ? HOLD_TWO_CLK : HOLD_ONE_CLK;
      nxt_state.used = 1'b1;
    end else begin
      nxt_state.holdoff = HOLD_ONE_CLK;
    end
    if (sampleNow) begin
      // Unused grant stands while its owner still wins its class
      if (!(winClass[state_ff.owner] && !state_ff.used)) begin
        if (pickAny) begin
          nxt_state.owner = pickIdx;
        end else if (state_ff.parkFixed) begin
          nxt_state.owner = state_ff.parkSel;
        end
        if (pickAny || state_ff.parkFixed) begin
          nxt_state.used = 1'b0;
        end
      end
    end
    nxt_state.grant = onehot4(nxt_state.owner);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_ff <= '{enable: EN_BOOT_HOST, prio: PRI_RESET, sampleDelay: 1'b0,
                    parkFixed: 1'b0, parkSel: OWNER_RESET, strapPending: 1'b1,
                    holdoff: HOLD_ONE_CLK, used: 1'b0, owner: OWNER_RESET,
                    grant: GRANT_RESET, rdata: ZERO_WORD};
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  assign regRdata = state_ff.rdata;
  assign bridgeGrant = state_ff.grant[0];
  assign busGrantN = ~state_ff.grant[3:1];

  // Checks
  AST_DISABLED_IGNORED: assert property (@(posedge clk) disable iff (!rstn)
    $rose(state_ff.grant[2]) |->
      $past(state_ff.enable[1] && !busRequestN[2]) ||
      $past(state_ff.parkFixed && state_ff.parkSel == 2'h2))
    else $error("Master 2 granted without enabled request or park");
  AST_BOOT_DEFAULT: assert property (@(posedge clk) disable iff (!rstn)
    (state_ff.strapPending && ce && !(regReq.wr && regReq.addr == CTRL_OFFSET)) |=>
      state_ff.enable == ($past(bootFromHost) ? EN_BOOT_HOST : EN_BOOT_PROC))
    else $error("Enable defaults do not follow boot option");
  AST_HIGH_FIRST: assert property (@(posedge clk) disable iff (!rstn)
    (ce && sampleNow && hiAny && !state_ff.used && !winClass[state_ff.owner]) |=>
      state_ff.prio[state_ff.owner])
    else $error("Low priority master won over high priority request");
  AST_BRIDGE_PRI_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && regReq.wr && regReq.addr == CTRL_OFFSET) |=>
      state_ff.prio[0] == $past(regReq.wdata[PRI_LSB]))
    else $error("Bridge priority not written");
  AST_FAST_SAMPLE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !transferStartN && !state_ff.sampleDelay) |=> !state_ff.holdoff)
    else $error("Sampling not one clock after start");
  AST_SLOW_SAMPLE_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    (ce && !transferStartN && state_ff.sampleDelay) ##1 (ce && transferStartN) |=>
      $stable(state_ff.owner))
    else $error("Grant moved one clock after start with delayed sampling");
  AST_PARK_FIXED: assert property (@(posedge clk) disable iff (!rstn)
    (ce && sampleNow && reqEn == 4'h0 && state_ff.parkFixed) |=>
      state_ff.grant == onehot4($past(state_ff.parkSel)))
    else $error("Idle bus not parked on programmed master");
  AST_PARK_LAST: assert property (@(posedge clk) disable iff (!rstn)
    (ce && reqEn == 4'h0 && !state_ff.parkFixed) |=> $stable(state_ff.owner))
    else $error("Idle bus did not stay on last master");
  AST_ONE_GRANT: assert property (@(posedge clk) disable iff (!rstn)
    $onehot({~busGrantN, bridgeGrant}))
    else $error("Grant pins not exactly one owner");
  AST_ROTATE: assert property (@(posedge clk) disable iff (!rstn)
    (ce && sampleNow && state_ff.used && (winClass & ~onehot4(state_ff.owner)) != 4'h0) |=>
      !$stable(state_ff.owner))
    else $error("Same-level requester starved after tenure");
  COV_EXT_GRANT: cover property (@(posedge clk) disable iff (!rstn) $fell(busGrantN[3]));
  COV_SLOW_START: cover property (@(posedge clk) disable iff (!rstn)
    !transferStartN && state_ff.sampleDelay);
  COV_PARK: cover property (@(posedge clk) disable iff (!rstn)
    sampleNow && reqEn == 4'h0 && state_ff.parkFixed);
endmodule
`default_nettype wire

// ---- pkg/arb_pkg.sv ----
// Constants and carrier types for the processor bus address arbiter.
// Assumes a single 125 MHz clock domain and a plain strobe register port.
package arb_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int MASTERS = 4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET = 12'h2d0;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h2d4;
  // Field positions in the control word
  localparam int EN_LSB = 17;
  localparam int PRI_LSB = 8;
  localparam int DLY_BIT = 3;
  localparam int PARK_BIT = 2;
  localparam int SEL_LSB = 0;
  // Field positions in the status word
  localparam int ST_OWNER_LSB = 0;
  localparam int ST_USED_BIT = 2;
  localparam int ST_HOLD_BIT = 3;
  localparam int ST_GRANT_LSB = 4;
  // Reset values and strap defaults
  localparam logic [2:0] EN_BOOT_HOST = 3'h0;
  localparam logic [2:0] EN_BOOT_PROC = 3'h1;
  localparam logic [3:0] PRI_RESET = 4'h0;
  localparam logic [1:0] OWNER_RESET = 2'h0;
  localparam logic [3:0] GRANT_RESET = 4'h1;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0;
  localparam logic HOLD_ONE_CLK = 1'b0;
  localparam logic HOLD_TWO_CLK = 1'b1;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } regbus_req_type;

  typedef struct packed {
    logic [2:0] enable;
    logic [3:0] prio;
    logic sampleDelay;
    logic parkFixed;
    logic [1:0] parkSel;
    logic strapPending;
    logic holdoff;
    logic used;
    logic [1:0] owner;
    logic [3:0] grant;
    logic [DATA_W-1:0] rdata;
  } arb_state_type;
endpackage

// ---- hw/rr_pick.sv ----
// Round-robin picker over four request bits.
// Assumes purely combinational use; search starts just after the last owner.
`timescale 1ns/1ns
`default_nettype none
module rr_pick #(
  parameter int N = 4
) (
  input wire logic [N-1:0] req,
  input wire logic [1:0] last,
  output logic any,
  output logic [1:0] idx
);
  always_comb begin
    int k;
    int c;
    k = 0;
    c = 0;
    any = 1'b0;
    idx = last;
    // Descending scan so the nearest successor wins
    for (k = N; k >= 1; k--) begin
      c = (int'(last) + k) % N;
      if (req[c]) begin
        any = 1'b1;
        idx = c[1:0];
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/ext_master_model.sv ----
// Model of the three external masters on the request and grant pins.
// Assumes active low grant levels; a granted master starts one transfer.
`timescale 1ns/1ns
`default_nettype none
module ext_master_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:1] want,
  input wire logic [3:1] busGrantN,
  output logic [3:1] busRequestN,
  output logic transferStartN
);
  logic [3:1] served;
  // Request released at the start, like a well behaved cache
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busRequestN <= 3'h7;
      transferStartN <= 1'b1;
      served <= 3'h0;
    end else begin
      transferStartN <= 1'b1;
      for (int n = 1; n <= 3; n++) begin
        busRequestN[n] <= !(want[n] && !served[n]);
        served[n] <= want[n] && served[n];
        if (!busGrantN[n] && !busRequestN[n] && !served[n] && transferStartN) begin
          transferStartN <= 1'b0;
          served[n] <= 1'b1;
          busRequestN[n] <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ---- dv/tb_processor_bus_arbiter.sv ----
// Bench for the processor bus arbiter: register port, grants and parking.
// Assumes ext_master_model drives the external request pins.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) begin checksDone++; if ((got) !== (exp)) begin numErrors++; \
  $display("unexpected %s exp %h got %h", nm, exp, got); end end
module tb_processor_bus_arbiter;
  import arb_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic bootFromHost = 1'b0;
  logic bridgeRequest = 1'b0;
  logic transferStartN;
  logic [3:1] want = 3'h0;
  logic [3:1] busRequestN;
  logic [3:1] busGrantN;
  logic bridgeGrant;
  logic [DATA_W-1:0] regRdata;
  regbus_req_type regReq = '0;
  int numErrors = 0;
  int checksDone = 0;
  wire [3:0] grantVec = {~busGrantN, bridgeGrant};

  initial forever #4 clk = ~clk;

  processor_bus_arbiter dut (.clk(clk), .rstn(rstn), .ce(ce), .regReq(regReq),
    .regRdata(regRdata), .bootFromHost(bootFromHost), .transferStartN(transferStartN),
    .bridgeRequest(bridgeRequest), .bridgeGrant(bridgeGrant), .busRequestN(busRequestN),
    .busGrantN(busGrantN));
  ext_master_model masters (.clk(clk), .rstn(rstn), .want(want), .busGrantN(busGrantN),
    .busRequestN(busRequestN), .transferStartN(transferStartN));

  task automatic closeOut();
    if (numErrors == 0 && checksDone > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic doReset(input logic boot);
    rstn <= 1'b0;
    bootFromHost <= boot;
    repeat (12) @(posedge clk);
    `CHK("grant in reset", 4'h1, grantVec)
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
  endtask

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    regReq.wr <= 1'b0;
  endtask

  task automatic regCheck(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    regReq <= '{addr: a, wdata: ZERO_WORD, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    regReq.rd <= 1'b0;
    #1 `CHK("regRdata", e, regRdata)
  endtask

  // Bounded wait, since grant latency depends on the sampling slot
  task automatic waitGrant(input logic [3:0] e, input int n);
    for (int i = 0; i < n && grantVec !== e; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK("grant", e, grantVec)
  endtask

  task automatic checkFields();
    regCheck(CTRL_OFFSET, 32'(EN_BOOT_PROC) << EN_LSB);
    regWrite(CTRL_OFFSET, 32'hffffffff);
    regCheck(CTRL_OFFSET, 32'h000e0f0f);
    regCheck(12'h2d8, ZERO_WORD);
    regWrite(CTRL_OFFSET, 32'(EN_BOOT_PROC) << EN_LSB);
  endtask

  // Frozen clock enable must drop a register write
  task automatic checkFreeze();
    ce <= 1'b0;
    regWrite(CTRL_OFFSET, 32'hffffffff);
    ce <= 1'b1;
    regCheck(CTRL_OFFSET, 32'(EN_BOOT_PROC) << EN_LSB);
  endtask

  task automatic checkEnable();
    want <= 3'h2;
    repeat (10) @(posedge clk);
    #1 `CHK("disabled grant", 4'h8, grantVec)
    want <= 3'h3;
    waitGrant(4'h2, 10);
    want <= 3'h0;
  endtask

  task automatic checkPark();
    for (int s = 3; s >= 0; s--) begin
      regWrite(CTRL_OFFSET, 32'h4 | 32'(s));
      waitGrant(4'(1 << s), 10);
    end
  endtask

  task automatic checkPriority();
    regWrite(CTRL_OFFSET, 32'h000e0808);
    want <= 3'h5;
    waitGrant(4'h8, 10);
    waitGrant(4'h2, 20);
    want <= 3'h0;
  endtask

  initial begin
    doReset(1'b0);
    checkFields();
    checkFreeze();
    checkEnable();
    checkPark();
    checkPriority();
    doReset(1'b1);
    regCheck(CTRL_OFFSET, ZERO_WORD);
    closeOut();
  end

  initial begin
    repeat (5000) @(posedge clk);
    numErrors++;
    closeOut();
  end
endmodule
`default_nettype wire
